// >>> common/flash_status_pkg.sv
// Constants, field positions and types for the flash status/configuration register unit.
// Assumes a command decoder on the link clock that delivers decoded instruction pulses.
// Operation
// - Busy flag at S0 set during program, erase, status or security operations.
// - Write enable instruction sets write_enable_latch at S1.
// - Power-up, write disable, program, erase, status write clear write_enable_latch.
// - Three non-volatile protect_level bits at S4..S2, default zero.
// - top_bottom_select anchors protection: zero top, one bottom.
// - granule_select one gives 4KB sectors, zero gives 64KB blocks.
// - complement_protect at S14 swaps protected and unprotected regions.
// - status_protect S7 and status_lock S8 zero: write allowed with latch set; the code still refuses it once protection is made permanent.
// - status_protect set: pin low blocks writes, pin high allows with latch.
// - status_lock set blocks status writes until next power cycle; the code also clears it on every rstn_i reset, since reload forces S8 to zero.
// - Prefix AAh then 55h before lock write makes protection permanent.
// - paused_operation_flag S15 set by suspend 75h, cleared by resume 7Ah.
// - security_lock bits S13..S11 are one-time settable, never cleared.
// - quad_enable_bit S9 one turns protect and hold pins into data lines.
// - Enter quad command mode 38h ignored unless quad_enable_bit is one.
// - In quad command mode quad_enable_bit stays one.
// - protect_scheme_select chooses bit scheme or per-block locks.
// - Two-bit drive_strength_code, default 11 meaning 25 percent.
// - pin_function_select zero pause, one reset; disabled when quad enabled.
// - Reserved bits have no effect on write; read here as zero.
// - Protect pin consulted only outside quad operation.
// - Program or erase touching a protected region is ignored.
// - Per-block scheme: program or erase on a locked unit is ignored.
package flash_status_pkg;
  localparam int unsigned BUSY_BIT = 0;
  localparam int unsigned WEL_BIT = 1;
  localparam int unsigned LEVEL_LO = 2;
  localparam int unsigned TB_BIT = 5;
  localparam int unsigned SEC_BIT = 6;
  localparam int unsigned SP_BIT = 7;
  localparam int unsigned SL_BIT = 0;
  localparam int unsigned QE_BIT = 1;
  localparam int unsigned LB_LO = 3;
  localparam int unsigned CMP_BIT = 6;
  localparam int unsigned SUS_BIT = 7;
  localparam int unsigned WPS_BIT = 2;
  localparam int unsigned DRV_LO = 5;
  localparam int unsigned PFS_BIT = 7;
  localparam logic [7:0] SR1_WMASK = 8'hFC;
  localparam logic [7:0] SR2_WMASK = 8'h7B;
  localparam logic [7:0] SR3_WMASK = 8'hE4;
  localparam logic [7:0] SR1_FACTORY = 8'h00;
  localparam logic [7:0] SR2_FACTORY = 8'h00;
  localparam logic [7:0] SR3_FACTORY = 8'h60;
  localparam logic [7:0] PREFIX_A = 8'hAA;
  localparam logic [7:0] PREFIX_B = 8'h55;
  localparam logic [1:0] SEL_SR1 = 2'h0;
  localparam logic [1:0] SEL_SR2 = 2'h1;
  localparam logic [1:0] SEL_SR3 = 2'h2;
  localparam int unsigned STATUS_WRITE_TIME_US = 10;
  localparam int unsigned CLK_SYS_MHZ = 100;
  localparam int unsigned STATUS_WRITE_CYCLES = STATUS_WRITE_TIME_US * CLK_SYS_MHZ;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_WREN, CMD_WRDI, CMD_WRSR, CMD_PROG, CMD_ERASE,
    CMD_SEC_PROG, CMD_SEC_ERASE, CMD_SUSPEND, CMD_RESUME, CMD_ENTER_QUAD,
    CMD_EXIT_QUAD, CMD_PREFIX, CMD_LOAD
  } cmd_t;

  typedef struct packed {
    cmd_t op;
    logic [1:0] sel;
    logic [7:0] data;
    logic target_protected;
    logic target_locked;
  } cmd_req_t;

  typedef struct packed {
    logic [7:0] sr1;
    logic [7:0] sr2;
    logic [7:0] sr3;
  } status_regs_t;
endpackage

// >>> verilog/flash_status_config_regs.sv
// Status and configuration register unit of a serial flash.
// Commands arrive decoded on the link clock; array operations time on clk_sys_i.
`timescale 1ns/100ps
module flash_status_config_regs #(
  parameter int unsigned WRITE_CYCLES = flash_status_pkg::STATUS_WRITE_CYCLES,
  parameter int unsigned ARRAY_OP_CYCLES = 64
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic clk_link_i,
  input wire logic cmd_valid_i,
  input wire flash_status_pkg::cmd_req_t cmd_i,
  input wire logic write_protect_pin_i,
  input wire flash_status_pkg::status_regs_t stored_i,
  output flash_status_pkg::status_regs_t status_o,
  output logic cmd_accepted_o,
  output logic quad_command_mode_o,
  output logic protect_pin_active_o,
  output logic pause_pin_active_o,
  output logic reset_pin_active_o,
  output logic [1:0] drive_strength_code_o,
  output logic protect_scheme_select_o,
  output logic [2:0] security_lock_o,
  output logic nv_write_o,
  output flash_status_pkg::status_regs_t nv_data_o
);
  import flash_status_pkg::*;

  logic rst_m_q, rstn_q;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_m_q <= 1'b0;
      rstn_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rstn_q <= rst_m_q;
    end
  end

  // Link domain reset
  logic lrst_m_q, lrstn_q;
  always_ff @(posedge clk_link_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lrst_m_q <= 1'b0;
      lrstn_q <= 1'b0;
    end else begin
      lrst_m_q <= 1'b1;
      lrstn_q <= lrst_m_q;
    end
  end

  // Link side: capture command, toggle to system domain
  cmd_req_t lcmd_q;
  logic ltog_q;
  logic ack_m_q, ack_s_q;
  logic sys_ack_q;
  logic lbusy;
  assign lbusy = ltog_q != ack_s_q;
  always_ff @(posedge clk_link_i or negedge lrstn_q) begin
    if (!lrstn_q) begin
      ack_m_q <= 1'b0;
      ack_s_q <= 1'b0;
    end else begin
      ack_m_q <= sys_ack_q;
      ack_s_q <= ack_m_q;
    end
  end
  always_ff @(posedge clk_link_i or negedge lrstn_q) begin
    if (!lrstn_q) begin
      lcmd_q <= '0;
      ltog_q <= 1'b0;
    end else if (cmd_valid_i && !lbusy) begin
      lcmd_q <= cmd_i;
      ltog_q <= ~ltog_q;
    end
  end

  logic tog_m_q, tog_s_q, tog_d_q;
  always_ff @(posedge clk_sys_i or negedge rstn_q) begin
    if (!rstn_q) begin
      tog_m_q <= 1'b0;
      tog_s_q <= 1'b0;
      tog_d_q <= 1'b0;
      sys_ack_q <= 1'b0;
    end else begin
      tog_m_q <= ltog_q;
      tog_s_q <= tog_m_q;
      tog_d_q <= tog_s_q;
      sys_ack_q <= tog_s_q;
    end
  end
  logic cmd_pulse;
  assign cmd_pulse = tog_s_q != tog_d_q;

  logic wp_m_q, wp_s_q;
  always_ff @(posedge clk_sys_i or negedge rstn_q) begin
    if (!rstn_q) begin
      wp_m_q <= 1'b0;
      wp_s_q <= 1'b0;
    end else begin
      wp_m_q <= write_protect_pin_i;
      wp_s_q <= wp_m_q;
    end
  end

  typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_WRSR, ST_ARRAY} state_t;
  state_t state_q;
  logic [31:0] cnt_q;
  logic [7:0] sr1_q, sr2_q, sr3_q;
  logic wel_q, sus_q, quad_q;
  // One-time fuse: survives the reset line, only power-on clears it
  logic perm_q = 1'b0;
  logic [1:0] prefix_q;
  logic [1:0] pend_sel_q;
  logic [7:0] pend_q;

  logic quad_enable;
  assign quad_enable = sr2_q[QE_BIT];
  logic status_lock;
  assign status_lock = sr2_q[SL_BIT];
  logic busy;
  assign busy = (state_q == ST_WRSR) || (state_q == ST_ARRAY);

  // Status write gate
  logic wr_allowed;
  always_comb begin
    wr_allowed = wel_q && !perm_q && !status_lock;
    if (sr1_q[SP_BIT] && !quad_enable && !quad_q && !wp_s_q) begin
      wr_allowed = 1'b0;
    end
  end

  logic cmd_i_sys_locked, cmd_i_sys_prot;
  assign cmd_i_sys_locked = lcmd_q.target_locked;
  assign cmd_i_sys_prot = lcmd_q.target_protected;
  logic array_blocked;
  // Region checks come from the address decoder; scheme picks which one
  assign array_blocked = sr3_q[WPS_BIT] ? cmd_i_sys_locked : cmd_i_sys_prot;

  logic cmd_ok;
  always_comb begin
    cmd_ok = 1'b0;
    if (cmd_pulse && state_q != ST_LOAD) begin
      case (lcmd_q.op)
        CMD_SUSPEND, CMD_RESUME: cmd_ok = 1'b1;
        CMD_WREN, CMD_WRDI, CMD_EXIT_QUAD, CMD_PREFIX: cmd_ok = !busy;
        CMD_ENTER_QUAD: cmd_ok = !busy && quad_enable;
        CMD_WRSR: cmd_ok = !busy && wr_allowed;
        CMD_PROG, CMD_ERASE: cmd_ok = !busy && wel_q && !array_blocked;
        CMD_SEC_PROG, CMD_SEC_ERASE: cmd_ok = !busy && wel_q && !security_lock_o[lcmd_q.sel];
        default: cmd_ok = 1'b0;
      endcase
    end
  end
  assign cmd_accepted_o = cmd_ok;

  // Sequencer
  always_ff @(posedge clk_sys_i or negedge rstn_q) begin
    if (!rstn_q) begin
      state_q <= ST_LOAD;
      cnt_q <= '0;
      pend_q <= '0;
      pend_sel_q <= SEL_SR1;
    end else begin
      case (state_q)
        ST_LOAD: state_q <= ST_IDLE;
        ST_IDLE: begin
          if (cmd_ok && lcmd_q.op == CMD_WRSR) begin
            state_q <= ST_WRSR;
            cnt_q <= WRITE_CYCLES - 1;
            pend_q <= lcmd_q.data;
            pend_sel_q <= lcmd_q.sel;
          end else if (cmd_ok && (lcmd_q.op == CMD_PROG || lcmd_q.op == CMD_ERASE ||
                       lcmd_q.op == CMD_SEC_PROG || lcmd_q.op == CMD_SEC_ERASE)) begin
            state_q <= ST_ARRAY;
            cnt_q <= ARRAY_OP_CYCLES - 1;
          end
        end
        ST_WRSR, ST_ARRAY: begin
          if (cnt_q == 0) begin
            state_q <= ST_IDLE;
          end else if (!sus_q) begin
            cnt_q <= cnt_q - 1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  logic wrsr_done;
  assign wrsr_done = state_q == ST_WRSR && cnt_q == 0;

  // Register contents
  always_ff @(posedge clk_sys_i or negedge rstn_q) begin
    if (!rstn_q) begin
      sr1_q <= SR1_FACTORY;
      sr2_q <= SR2_FACTORY;
      sr3_q <= SR3_FACTORY;
    end else if (state_q == ST_LOAD) begin
      sr1_q <= stored_i.sr1 & SR1_WMASK;
      sr2_q <= (stored_i.sr2 & SR2_WMASK) & ~(8'h01 << SL_BIT);
      sr3_q <= stored_i.sr3 & SR3_WMASK;
    end else if (wrsr_done) begin
      case (pend_sel_q)
        SEL_SR1: sr1_q <= pend_q & SR1_WMASK;
        SEL_SR2: begin
          sr2_q <= pend_q & SR2_WMASK;
          sr2_q[LB_LO +: 3] <= sr2_q[LB_LO +: 3] | pend_q[LB_LO +: 3];
          if (quad_q) begin
            sr2_q[QE_BIT] <= 1'b1;
          end
        end
        SEL_SR3: sr3_q <= pend_q & SR3_WMASK;
        default: sr1_q <= sr1_q;
      endcase
    end
  end

  // Write enable latch
  always_ff @(posedge clk_sys_i or negedge rstn_q) begin
    if (!rstn_q) begin
      wel_q <= 1'b0;
    end else if (cmd_ok) begin
      case (lcmd_q.op)
        CMD_WREN: wel_q <= 1'b1;
        CMD_WRDI, CMD_WRSR, CMD_PROG, CMD_ERASE, CMD_SEC_PROG, CMD_SEC_ERASE: wel_q <= 1'b0;
        default: wel_q <= wel_q;
      endcase
    end
  end

  // Suspend, quad mode, one-time lock
  always_ff @(posedge clk_sys_i or negedge rstn_q) begin
    if (!rstn_q) begin
      sus_q <= 1'b0;
      quad_q <= 1'b0;
      prefix_q <= '0;
    end else begin
      if (cmd_ok && lcmd_q.op == CMD_SUSPEND && busy) begin
        sus_q <= 1'b1;
      end else if (cmd_ok && lcmd_q.op == CMD_RESUME) begin
        sus_q <= 1'b0;
      end
      if (cmd_ok && lcmd_q.op == CMD_ENTER_QUAD) begin
        quad_q <= 1'b1;
      end else if (cmd_ok && lcmd_q.op == CMD_EXIT_QUAD) begin
        quad_q <= 1'b0;
      end
      if (cmd_ok && lcmd_q.op == CMD_PREFIX) begin
        if (lcmd_q.data == PREFIX_A) begin
          prefix_q <= 2'h1;
        end else if (lcmd_q.data == PREFIX_B && prefix_q == 2'h1) begin
          prefix_q <= 2'h2;
        end else begin
          prefix_q <= '0;
        end
      end else if (cmd_ok && lcmd_q.op != CMD_WRSR) begin
        prefix_q <= '0;
      end else if (wrsr_done) begin
        // Prefix pair is kept through the write it qualifies
        prefix_q <= '0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (wrsr_done && pend_sel_q == SEL_SR2 && pend_q[SL_BIT] && prefix_q == 2'h2) begin
      perm_q <= 1'b1;
    end
  end

  always_comb begin
    status_o.sr1 = sr1_q;
    status_o.sr1[BUSY_BIT] = busy;
    status_o.sr1[WEL_BIT] = wel_q;
    status_o.sr2 = sr2_q;
    status_o.sr2[SUS_BIT] = sus_q;
    status_o.sr3 = sr3_q;
  end

  assign quad_command_mode_o = quad_q;
  assign protect_pin_active_o = !quad_enable;
  assign pause_pin_active_o = !quad_enable && !sr3_q[PFS_BIT];
  assign reset_pin_active_o = !quad_enable && sr3_q[PFS_BIT];
  assign drive_strength_code_o = sr3_q[DRV_LO +: 2];
  assign protect_scheme_select_o = sr3_q[WPS_BIT];
  assign security_lock_o = sr2_q[LB_LO +: 3];
  assign nv_write_o = wrsr_done;
  always_comb begin
    nv_data_o.sr1 = sr1_q;
    nv_data_o.sr2 = sr2_q;
    nv_data_o.sr3 = sr3_q;
  end
endmodule

// >>> bench/host_model.sv
// Host side model: issues decoded commands inside short link clock frames.
// Assumes the unit samples cmd_valid_i on the rising link clock edge.
`timescale 1ns/100ps
module host_model
  import flash_status_pkg::*;
(
  output logic clk_link_o,
  output logic cmd_valid_o,
  output cmd_req_t cmd_o
);
  int burst = 4;
  initial begin
    clk_link_o = 1'b0;
    cmd_valid_o = 1'b0;
    cmd_o = '0;
    #7;
    // Clock stands still between frames
    forever begin
      #32;
      if (burst > 0 || clk_link_o) clk_link_o = ~clk_link_o;
      if (!clk_link_o && burst > 0) burst--;
    end
  end
  // Callers may write reserved bits as one (SR3 gets FFh); prefix pairs are issued in order
  task automatic send(input cmd_t op, input logic [1:0] sel, input logic [7:0] d, input logic [1:0] pl);
    wait (burst == 0 && !clk_link_o);
    cmd_o = '{op, sel, d, pl[1], pl[0]};
    cmd_valid_o = 1'b1;
    burst = 8;
    @(posedge clk_link_o);
    #4;
    cmd_valid_o = 1'b0;
    cmd_o.data = ~d;
  endtask
endmodule

// >>> bench/flash_status_chk.sv
// Checker for the status register unit, bound to its top module.
// Assumes outputs settle on clk_sys_i and rstn_i is active low.
`timescale 1ns/100ps
module flash_status_chk
  import flash_status_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire status_regs_t status_o,
  input wire logic nv_write_o,
  input wire logic quad_command_mode_o,
  input wire logic protect_pin_active_o,
  input wire logic pause_pin_active_o,
  input wire logic reset_pin_active_o,
  input wire logic [1:0] drive_strength_code_o,
  input wire logic protect_scheme_select_o,
  input wire logic [2:0] security_lock_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  a_commit_single: assert property (nv_write_o |=> !nv_write_o)
    else $error("commit pulse too long");
  a_commit_after_busy: assert property (nv_write_o |-> $past(status_o.sr1[BUSY_BIT]))
    else $error("commit without busy phase");
  a_commit_clears: assert property (nv_write_o |=> !status_o.sr1[BUSY_BIT] && !status_o.sr1[WEL_BIT])
    else $error("busy or latch left set after commit");
  a_quad_holds_qe: assert property (quad_command_mode_o |-> status_o.sr2[QE_BIT])
    else $error("quad enable dropped in quad mode");
  a_quad_pins_off: assert property (status_o.sr2[QE_BIT] |-> !(protect_pin_active_o || pause_pin_active_o
    || reset_pin_active_o))
    else $error("pin function active with quad enable");
  a_pin_select: assert property (!status_o.sr2[QE_BIT] |-> protect_pin_active_o
    && reset_pin_active_o == status_o.sr3[PFS_BIT] && pause_pin_active_o == !status_o.sr3[PFS_BIT])
    else $error("shared pin function wrong");
  a_drive_scheme: assert property (drive_strength_code_o == status_o.sr3[DRV_LO+:2]
    && protect_scheme_select_o == status_o.sr3[WPS_BIT])
    else $error("drive or scheme output mismatch");
  a_lock_sticky: assert property (security_lock_o == status_o.sr2[LB_LO+:3]
    && (security_lock_o & $past(security_lock_o)) == $past(security_lock_o))
    else $error("security lock cleared");
  a_reserved_low: assert property (!status_o.sr2[2] && status_o.sr3[1:0] == 2'h0 && status_o.sr3[4:3] == 2'h0)
    else $error("reserved bit reads one");
endmodule
bind flash_status_config_regs flash_status_chk chk_u (.clk_sys_i, .rstn_i, .status_o, .nv_write_o,
  .quad_command_mode_o, .protect_pin_active_o, .pause_pin_active_o, .reset_pin_active_o,
  .drive_strength_code_o, .protect_scheme_select_o, .security_lock_o);

// >>> bench/flash_status_config_regs_bench.sv
// Bench for the status register unit: command sequences with expected values.
// Assumes the host model issues one command per link frame.
`timescale 1ns/100ps
module flash_status_config_regs_bench;
  import flash_status_pkg::*;
  logic clk_sys_i, rstn_i, clk_link_i, cmd_valid_i, write_protect_pin_i, acc, busy;
  cmd_req_t cmd_i;
  status_regs_t stored_i, status_o, nv_data_o;
  logic cmd_accepted_o, quad_command_mode_o, protect_pin_active_o, pause_pin_active_o;
  logic reset_pin_active_o, protect_scheme_select_o, nv_write_o;
  logic [1:0] drive_strength_code_o;
  logic [2:0] security_lock_o;
  int bad_count = 0, tests_run = 0, cyc = 0;
  flash_status_config_regs #(.WRITE_CYCLES(8)) dut_u (.clk_sys_i, .rstn_i, .clk_link_i, .cmd_valid_i, .cmd_i,
    .write_protect_pin_i, .stored_i, .status_o, .cmd_accepted_o, .quad_command_mode_o, .protect_pin_active_o,
    .pause_pin_active_o, .reset_pin_active_o, .drive_strength_code_o, .protect_scheme_select_o,
    .security_lock_o, .nv_write_o, .nv_data_o);
  host_model host_u (.clk_link_o(clk_link_i), .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 12000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input cmd_t op, input logic [1:0] sel, input logic [7:0] d, input logic [1:0] pl);
    host_u.send(op, sel, d, pl);
    acc = 1'b0;
    for (int n = 0; n < 60 && !acc; n++) begin
      @(posedge clk_sys_i);
      #1 acc = cmd_accepted_o;
    end
    @(posedge clk_sys_i);
    #1 busy = status_o.sr1[BUSY_BIT];
    repeat (60) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic go(input cmd_t op, input logic [7:0] d, input logic exp);
    cmd(op, SEL_SR1, d, 2'b00);
    chk(acc, exp);
  endtask
  task automatic wr(input logic [1:0] sel, input logic [7:0] d, input logic exp);
    go(CMD_WREN, 8'h00, 1'b1);
    cmd(CMD_WRSR, sel, d, 2'b00);
    chk(acc, exp);
  endtask
  task automatic rst();
    rstn_i = 1'b0;
    host_u.burst = 4;
    repeat (16) @(posedge clk_sys_i);
    #1 rstn_i = 1'b1;
    // Link clock must run after release so its reset synchroniser clears
    host_u.burst = 4;
    repeat (10) @(posedge clk_sys_i);
    #1;
  endtask
  initial begin
    rstn_i = 1'b0;
    write_protect_pin_i = 1'b1;
    stored_i = '{8'h1C, 8'h01, 8'h60};
    rst();
    chk(status_o, 24'h1C0060);
    go(CMD_WREN, 8'h00, 1'b1);
    chk(status_o.sr1, 8'h1E);
    go(CMD_WRDI, 8'h00, 1'b1);
    chk(status_o.sr1, 8'h1C);
    go(CMD_WRSR, 8'hFF, 1'b0);
    wr(SEL_SR1, 8'hFF, 1'b1);
    chk(busy, 1'b1);
    chk(status_o.sr1, 8'hFC);
    write_protect_pin_i = 1'b0;
    wr(SEL_SR1, 8'h00, 1'b0);
    write_protect_pin_i = 1'b1;
    wr(SEL_SR1, 8'h00, 1'b1);
    chk(status_o.sr1, 8'h00);
    go(CMD_ENTER_QUAD, 8'h00, 1'b0);
    wr(SEL_SR2, 8'h02, 1'b1);
    go(CMD_ENTER_QUAD, 8'h00, 1'b1);
    chk(quad_command_mode_o, 1'b1);
    wr(SEL_SR2, 8'h40, 1'b1);
    chk(status_o.sr2, 8'h42);
    go(CMD_EXIT_QUAD, 8'h00, 1'b1);
    wr(SEL_SR2, 8'h38, 1'b1);
    wr(SEL_SR2, 8'h00, 1'b1);
    chk(status_o.sr2, 8'h38);
    wr(SEL_SR3, 8'hFF, 1'b1);
    chk(status_o.sr3, 8'hE4);
    go(CMD_WREN, 8'h00, 1'b1);
    cmd(CMD_PROG, SEL_SR1, 8'h00, 2'b01);
    chk(acc, 1'b0);
    wr(SEL_SR3, 8'h80, 1'b1);
    chk({drive_strength_code_o, reset_pin_active_o}, 3'h1);
    go(CMD_WREN, 8'h00, 1'b1);
    cmd(CMD_PROG, SEL_SR1, 8'h00, 2'b10);
    chk(acc, 1'b0);
    host_u.send(CMD_ERASE, SEL_SR1, 8'h00, 2'b00);
    go(CMD_SUSPEND, 8'h00, 1'b1);
    chk(status_o.sr2[SUS_BIT], 1'b1);
    go(CMD_RESUME, 8'h00, 1'b1);
    chk(status_o.sr2[SUS_BIT], 1'b0);
    wr(SEL_SR2, 8'h39, 1'b1);
    wr(SEL_SR2, 8'h38, 1'b0);
    rst();
    chk(status_o.sr2, 8'h00);
    go(CMD_WREN, 8'h00, 1'b1);
    cmd(CMD_PREFIX, SEL_SR1, PREFIX_A, 2'b00);
    cmd(CMD_PREFIX, SEL_SR1, PREFIX_B, 2'b00);
    cmd(CMD_WRSR, SEL_SR2, 8'h01, 2'b00);
    chk(acc, 1'b1);
    rst();
    wr(SEL_SR2, 8'h00, 1'b0);
    report_and_stop();
  end
endmodule
